// *** rtl/hps_pkg.sv ***
// Purpose: Shared constants for the hub port swap and remap configuration block
// Assumes: Registers reached over AHB-Lite, one aligned word per register
// Notes: Printed offsets are register indices; the byte address is four times the index
package hps_pkg;
	// Register indices as printed, and their byte addresses
	localparam logic [7:0] IDX_CFG_BYTE3 = 8'h08;
	localparam logic [7:0] IDX_SWAP = 8'hfa;
	localparam logic [7:0] IDX_REMAP12 = 8'hfb;
	localparam logic [31:0] ADDR_CFG_BYTE3 = {22'h000000, IDX_CFG_BYTE3, 2'h0};
	localparam logic [31:0] ADDR_SWAP = {22'h000000, IDX_SWAP, 2'h0};
	localparam logic [31:0] ADDR_REMAP12 = {22'h000000, IDX_REMAP12, 2'h0};
	// Read-only status word of the effective mapping
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0400;

	// Reset values
	localparam logic [7:0] RST_SWAP = 8'h00;
	localparam logic [7:0] RST_REMAP12 = 8'h00;
	localparam logic [7:0] RST_CFG_BYTE3 = 8'h00;

	// Field layout
	localparam int REMAP_EN_BIT = 3;
	localparam int UPSTREAM_BIT = 0;
	localparam int FIELD_W = 4;
	localparam int FIELD_LO_LSB = 0;
	localparam int FIELD_HI_LSB = 4;
	localparam int LOG_W = 3;
	localparam logic [3:0] MAP_DISABLED = 4'h0;
	localparam logic [3:0] MAP_LAST = 4'h7;
	localparam logic [2:0] ID_PHYS1 = 3'h1;
	localparam logic [2:0] ID_PHYS2 = 3'h2;

	// Status word layout
	localparam int ST_PHYS1_LSB = 0;
	localparam int ST_PHYS2_LSB = 4;
	localparam int ST_COUNT_LSB = 8;
	localparam int ST_ACTIVE_BIT = 16;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;
endpackage

// *** rtl/hps_config.sv ***
// Purpose: Data pin swap and physical-to-logical remap for ports 1 and 2 of a hub
// Assumes: AHB-Lite single word transfers; zero wait states; function side synchronous
// Notes: Pin routing and map outputs are registered, one cycle behind their inputs
// Operation
// (R01) Eight-bit swap mask holds one bit per port.
// (R02) Swap bit clear: D+ uses the DP pin, D- the DM pin.
// (R03) Swap bit set: D+ uses the DM pin, D- the DP pin.
// (R04) Mask bit zero swaps the upstream port.
// (R05) Mask bit N swaps downstream port N, for N one to seven.
// (R06) Eight-bit remap register holds one nibble per physical port 1 and 2.
// (R07) Upper nibble zero disables physical port 2.
// (R08) Upper nibble one to five maps port 2 to logical ports 1 to 5.
// (R09) Remapping applies only while the remap enable bit is set.
// (R10) Hub reports only a port count, never a numbering.
// (R11) Host numbers downstream ports from one up to the reported count.
// (R12) Software assigns logical numbers contiguously from one.
// (R13) Upper nibble six and seven map port 2 to logical 6 and 7.
// (R14) Lower nibble maps physical port 1 with the same encoding.
// (R15) Field values eight to fifteen act as zero, port disabled.
// (R16) Remap disabled: each physical port keeps its own number.
`timescale 1ns/1ps
module hps_config #(
	parameter int NUM_PORTS = 8
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	input wire logic [NUM_PORTS-1:0] I_FN_DP_O,
	input wire logic [NUM_PORTS-1:0] I_FN_DM_O,
	input wire logic [NUM_PORTS-1:0] I_FN_DP_OE,
	input wire logic [NUM_PORTS-1:0] I_FN_DM_OE,
	output logic [NUM_PORTS-1:0] O_FN_DP_I,
	output logic [NUM_PORTS-1:0] O_FN_DM_I,
	input wire logic [NUM_PORTS-1:0] I_PIN_DP_I,
	input wire logic [NUM_PORTS-1:0] I_PIN_DM_I,
	output logic [NUM_PORTS-1:0] O_PIN_DP_O,
	output logic [NUM_PORTS-1:0] O_PIN_DM_O,
	output logic [NUM_PORTS-1:0] O_PIN_DP_OE,
	output logic [NUM_PORTS-1:0] O_PIN_DM_OE,
	output logic O_REMAP_ACTIVE,
	output logic [2:0] O_PHYS1_LOGICAL,
	output logic [2:0] O_PHYS2_LOGICAL,
	output logic [3:0] O_PORT_COUNT
);

////////////////////////////////////////////////////////////////////////////////
	// Mask is eight bits wide, so at most eight ports; ports 1 and 2 must exist
	if (NUM_PORTS < 3 || NUM_PORTS > 8) begin : g_bad_ports
		$error("NUM_PORTS must lie between 3 and 8");
	end

	logic [7:0] swap_ff;
	logic [7:0] nxt_swap;
	logic [7:0] remap_ff;
	logic [7:0] nxt_remap;
	logic [7:0] cfg3_ff;
	logic [7:0] nxt_cfg3;
	logic wr_pend_ff;
	logic nxt_wr_pend;
	logic [31:0] wr_addr_ff;
	logic [31:0] nxt_wr_addr;
	logic [31:0] nxt_rdata;
	logic addr_phase;
	logic [31:0] status_word;

////////////////////////////////////////////////////////////////////////////////
	// Bus slave answers in zero wait states and never errors
	assign O_HREADYOUT = 1'h1;
	assign O_HRESP = hps_pkg::HRESP_OKAY;
	assign addr_phase = I_HSEL && (I_HTRANS == hps_pkg::HTRANS_NONSEQ) && I_HREADY;

	// Write capture: address phase remembered, data applied in the data phase
	always_comb begin
		nxt_wr_pend = addr_phase && I_HWRITE;
		nxt_wr_addr = wr_addr_ff;
		if (addr_phase && I_HWRITE) begin
			nxt_wr_addr = I_HADDR;
		end
		nxt_swap = swap_ff;
		nxt_remap = remap_ff;
		nxt_cfg3 = cfg3_ff;
		// Only the low byte carries data; unmapped writes are dropped
		if (wr_pend_ff) begin
			if (wr_addr_ff == hps_pkg::ADDR_SWAP) begin
				nxt_swap = I_HWDATA[7:0]; // R01
			end else if (wr_addr_ff == hps_pkg::ADDR_REMAP12) begin
				nxt_remap = I_HWDATA[7:0]; // R06
			end else if (wr_addr_ff == hps_pkg::ADDR_CFG_BYTE3) begin
				nxt_cfg3 = I_HWDATA[7:0];
			end
		end
	end

	// Register read data is built from next values, so a read right after a write sees it; status uses the registered map
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (addr_phase && !I_HWRITE) begin
			if (I_HADDR == hps_pkg::ADDR_SWAP) begin
				nxt_rdata = {24'h000000, nxt_swap};
			end else if (I_HADDR == hps_pkg::ADDR_REMAP12) begin
				nxt_rdata = {24'h000000, nxt_remap};
			end else if (I_HADDR == hps_pkg::ADDR_CFG_BYTE3) begin
				nxt_rdata = {24'h000000, nxt_cfg3};
			end else if (I_HADDR == hps_pkg::ADDR_STATUS) begin
				nxt_rdata = status_word;
			end
		end
	end

	// Register bank and bus pipeline
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			swap_ff <= hps_pkg::RST_SWAP;
			remap_ff <= hps_pkg::RST_REMAP12;
			cfg3_ff <= hps_pkg::RST_CFG_BYTE3;
			wr_pend_ff <= 1'h0;
			wr_addr_ff <= 32'h0000_0000;
			O_HRDATA <= 32'h0000_0000;
		end else begin
			swap_ff <= nxt_swap;
			remap_ff <= nxt_remap;
			cfg3_ff <= nxt_cfg3;
			wr_pend_ff <= nxt_wr_pend;
			wr_addr_ff <= nxt_wr_addr;
			O_HRDATA <= nxt_rdata;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// Pin routing; outputs are registered, costing one cycle of latency
	logic [NUM_PORTS-1:0] nxt_pin_dp_o;
	logic [NUM_PORTS-1:0] nxt_pin_dm_o;
	logic [NUM_PORTS-1:0] nxt_pin_dp_oe;
	logic [NUM_PORTS-1:0] nxt_pin_dm_oe;
	logic [NUM_PORTS-1:0] nxt_fn_dp_i;
	logic [NUM_PORTS-1:0] nxt_fn_dm_i;

	// Bit 0 is the upstream port, bit N downstream port N
	for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
		assign nxt_pin_dp_o[i] = swap_ff[i] ? I_FN_DM_O[i] : I_FN_DP_O[i]; // R02 R03 R04 R05
		assign nxt_pin_dm_o[i] = swap_ff[i] ? I_FN_DP_O[i] : I_FN_DM_O[i]; // R02 R03
		assign nxt_pin_dp_oe[i] = swap_ff[i] ? I_FN_DM_OE[i] : I_FN_DP_OE[i]; // R02 R03
		assign nxt_pin_dm_oe[i] = swap_ff[i] ? I_FN_DP_OE[i] : I_FN_DM_OE[i]; // R02 R03
		assign nxt_fn_dp_i[i] = swap_ff[i] ? I_PIN_DM_I[i] : I_PIN_DP_I[i]; // R02 R03
		assign nxt_fn_dm_i[i] = swap_ff[i] ? I_PIN_DP_I[i] : I_PIN_DM_I[i]; // R02 R03
	end

	// Registered pin side
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_PIN_DP_O <= '0;
			O_PIN_DM_O <= '0;
			O_PIN_DP_OE <= '0;
			O_PIN_DM_OE <= '0;
			O_FN_DP_I <= '0;
			O_FN_DM_I <= '0;
		end else begin
			O_PIN_DP_O <= nxt_pin_dp_o;
			O_PIN_DM_O <= nxt_pin_dm_o;
			O_PIN_DP_OE <= nxt_pin_dp_oe;
			O_PIN_DM_OE <= nxt_pin_dm_oe;
			O_FN_DP_I <= nxt_fn_dp_i;
			O_FN_DM_I <= nxt_fn_dm_i;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// Field decode: reserved codes fall back to disabled
	function automatic logic [2:0] decode_field(input logic [3:0] f);
		logic [2:0] r;
		r = 3'h0;
		if (f != hps_pkg::MAP_DISABLED && f <= hps_pkg::MAP_LAST) begin
			r = f[2:0]; // R07 R08 R13 R14
		end
		return r; // R15
	endfunction

	logic remap_on;
	logic [3:0] field_lo;
	logic [3:0] field_hi;
	logic [2:0] nxt_phys1;
	logic [2:0] nxt_phys2;
	logic [3:0] nxt_count;

	assign remap_on = cfg3_ff[hps_pkg::REMAP_EN_BIT];
	assign field_lo = remap_ff[hps_pkg::FIELD_LO_LSB +: hps_pkg::FIELD_W];
	assign field_hi = remap_ff[hps_pkg::FIELD_HI_LSB +: hps_pkg::FIELD_W];

	// Effective map; the count is all the hub exposes to the host
	always_comb begin
		nxt_phys1 = hps_pkg::ID_PHYS1; // R16
		nxt_phys2 = hps_pkg::ID_PHYS2; // R16
		if (remap_on) begin
			nxt_phys1 = decode_field(field_lo); // R09 R14
			nxt_phys2 = decode_field(field_hi); // R09
		end
		// No check of contiguity here; software keeps numbers dense
		nxt_count = 4'(NUM_PORTS - 1); // R10
		if (nxt_phys1 == 3'h0) begin
			nxt_count = nxt_count - 4'h1;
		end
		if (nxt_phys2 == 3'h0) begin
			nxt_count = nxt_count - 4'h1;
		end
	end

	// Registered map outputs
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_REMAP_ACTIVE <= 1'h0;
			O_PHYS1_LOGICAL <= hps_pkg::ID_PHYS1;
			O_PHYS2_LOGICAL <= hps_pkg::ID_PHYS2;
			O_PORT_COUNT <= 4'(NUM_PORTS - 1);
		end else begin
			O_REMAP_ACTIVE <= remap_on;
			O_PHYS1_LOGICAL <= nxt_phys1;
			O_PHYS2_LOGICAL <= nxt_phys2;
			O_PORT_COUNT <= nxt_count;
		end
	end

	// Status word mirrors the registered map
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[hps_pkg::ST_PHYS1_LSB +: 3] = O_PHYS1_LOGICAL;
		status_word[hps_pkg::ST_PHYS2_LSB +: 3] = O_PHYS2_LOGICAL;
		status_word[hps_pkg::ST_COUNT_LSB +: 4] = O_PORT_COUNT;
		status_word[hps_pkg::ST_ACTIVE_BIT] = O_REMAP_ACTIVE;
	end

////////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_swap_write_lands: assert property (@(posedge I_CLK) disable iff (I_RST) // R01
		(addr_phase && I_HWRITE && I_HADDR == hps_pkg::ADDR_SWAP)
		##1 1'h1 |=> swap_ff == $past(I_HWDATA[7:0]))
		else $error("swap mask write lost");

	chk_clear_dp_path: assert property (@(posedge I_CLK) disable iff (I_RST) // R02
		// Skip the first edge after reset: its outputs are reset values, not routed ones
		!$past(I_RST) |->
		((O_PIN_DP_O ^ $past(I_FN_DP_O)) & ~$past(swap_ff[NUM_PORTS-1:0])) == '0)
		else $error("unswapped DP pin wrong");

	chk_set_dm_path: assert property (@(posedge I_CLK) disable iff (I_RST) // R03
		##1 1'h1 |-> ((O_PIN_DM_O ^ $past(I_FN_DP_O)) & $past(swap_ff[NUM_PORTS-1:0])) == '0)
		else $error("swapped DM pin wrong");

	chk_set_rx_path: assert property (@(posedge I_CLK) disable iff (I_RST) // R03
		##1 1'h1 |-> ((O_FN_DP_I ^ $past(I_PIN_DM_I)) & $past(swap_ff[NUM_PORTS-1:0])) == '0)
		else $error("swapped receive path wrong");

	chk_upstream_swap: assert property (@(posedge I_CLK) disable iff (I_RST) // R04
		swap_ff[hps_pkg::UPSTREAM_BIT] |=>
		O_PIN_DP_OE[hps_pkg::UPSTREAM_BIT] == $past(I_FN_DM_OE[hps_pkg::UPSTREAM_BIT]))
		else $error("upstream swap wrong");

	chk_down1_swap: assert property (@(posedge I_CLK) disable iff (I_RST) // R05
		swap_ff[1] |=> O_PIN_DM_OE[1] == $past(I_FN_DP_OE[1]))
		else $error("downstream port 1 swap wrong");

	chk_remap_hi_valid: assert property (@(posedge I_CLK) disable iff (I_RST) // R08
		remap_on && field_hi != 4'h0 && !field_hi[3] |=> O_PHYS2_LOGICAL == $past(field_hi[2:0]))
		else $error("port 2 mapping wrong");

	chk_remap_lo_valid: assert property (@(posedge I_CLK) disable iff (I_RST) // R14
		remap_on && field_lo != 4'h0 && !field_lo[3] |=> O_PHYS1_LOGICAL == $past(field_lo[2:0]))
		else $error("port 1 mapping wrong");

	chk_reserved_off: assert property (@(posedge I_CLK) disable iff (I_RST) // R15
		remap_on && (field_hi[3] || field_hi == 4'h0) |=> O_PHYS2_LOGICAL == 3'h0)
		else $error("reserved code not disabled");

	chk_identity_map: assert property (@(posedge I_CLK) disable iff (I_RST) // R16
		!remap_on |=> O_PHYS1_LOGICAL == 3'h1 && O_PHYS2_LOGICAL == 3'h2 && !O_REMAP_ACTIVE)
		else $error("identity map broken");

	chk_port_count: assert property (@(posedge I_CLK) disable iff (I_RST) // R10
		##1 1'h1 |-> O_PORT_COUNT == 4'(NUM_PORTS - 1)
		- 4'(O_PHYS1_LOGICAL == 3'h0) - 4'(O_PHYS2_LOGICAL == 3'h0))
		else $error("reported count wrong");

////////////////////////////////////////////////////////////////////////////////
	// Checks on the routes not covered above and on every class of remap code
	// Pin outputs, DM receive and DP enable are checked on both sides of their swap bit (DP enable set at bit 0 only);
	// DP receive is checked only with the bit set, and DM enable only set and at bit 1
	chk_clear_dm_path: assert property (@(posedge I_CLK) disable iff (I_RST) // R02
		!$past(I_RST) |->
		((O_PIN_DM_O ^ $past(I_FN_DM_O)) & ~$past(swap_ff[NUM_PORTS-1:0])) == '0)
		else $error("unswapped DM pin wrong");

	chk_clear_rx_path: assert property (@(posedge I_CLK) disable iff (I_RST) // R02
		!$past(I_RST) |->
		((O_FN_DM_I ^ $past(I_PIN_DM_I)) & ~$past(swap_ff[NUM_PORTS-1:0])) == '0)
		else $error("unswapped receive path wrong");

	chk_clear_oe_path: assert property (@(posedge I_CLK) disable iff (I_RST) // R02
		!$past(I_RST) |->
		((O_PIN_DP_OE ^ $past(I_FN_DP_OE)) & ~$past(swap_ff[NUM_PORTS-1:0])) == '0)
		else $error("unswapped DP enable wrong");

	chk_set_dp_path: assert property (@(posedge I_CLK) disable iff (I_RST) // R03
		!$past(I_RST) |->
		((O_PIN_DP_O ^ $past(I_FN_DM_O)) & $past(swap_ff[NUM_PORTS-1:0])) == '0)
		else $error("swapped DP pin wrong");

	chk_set_rx_dm: assert property (@(posedge I_CLK) disable iff (I_RST) // R03
		!$past(I_RST) |->
		((O_FN_DM_I ^ $past(I_PIN_DP_I)) & $past(swap_ff[NUM_PORTS-1:0])) == '0)
		else $error("swapped DM receive path wrong");

	chk_top_pin_swap: assert property (@(posedge I_CLK) disable iff (I_RST) // R05
		swap_ff[NUM_PORTS-1] |=> O_PIN_DP_O[NUM_PORTS-1] == $past(I_FN_DM_O[NUM_PORTS-1]))
		else $error("top downstream port swap wrong");

	chk_remap_write_lands: assert property (@(posedge I_CLK) disable iff (I_RST) // R06
		(addr_phase && I_HWRITE && I_HADDR == hps_pkg::ADDR_REMAP12)
		##1 1'h1 |=> remap_ff == $past(I_HWDATA[7:0]))
		else $error("remap write lost");

	chk_hi_disabled: assert property (@(posedge I_CLK) disable iff (I_RST) // R07
		remap_on && field_hi == hps_pkg::MAP_DISABLED |=> O_PHYS2_LOGICAL == 3'h0)
		else $error("port 2 not disabled");

	chk_hi_upper_codes: assert property (@(posedge I_CLK) disable iff (I_RST) // R13
		remap_on && field_hi[3:1] == 3'h3 |=> O_PHYS2_LOGICAL == $past(field_hi[2:0]))
		else $error("port 2 upper codes wrong");

	chk_lo_disabled: assert property (@(posedge I_CLK) disable iff (I_RST) // R14
		remap_on && field_lo == hps_pkg::MAP_DISABLED |=> O_PHYS1_LOGICAL == 3'h0)
		else $error("port 1 not disabled");

	chk_lo_reserved: assert property (@(posedge I_CLK) disable iff (I_RST) // R15
		remap_on && field_lo[3] |=> O_PHYS1_LOGICAL == 3'h0)
		else $error("port 1 reserved code not disabled");

	chk_remap_gate: assert property (@(posedge I_CLK) disable iff (I_RST) // R09
		remap_on |=> O_REMAP_ACTIVE)
		else $error("remap enable not applied");

endmodule

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench for the hub port swap and remap block
// Assumes: Zero wait slave; bus hready is the slave's own hreadyout
// Notes: Map and pin outputs are checked two edges after their cause
`timescale 1ns/1ps
module tb_top;
	localparam int NP = 8;
	logic clk, rst, hsel, hwrite;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire logic hready;
	logic hresp;
	logic [NP-1:0] dp_o, dm_o, dp_oe, dm_oe, pdp_i, pdm_i;
	logic [NP-1:0] fdp_i, fdm_i, pdp_o, pdm_o, pdp_oe, pdm_oe;
	logic active;
	logic [2:0] p1, p2;
	logic [3:0] cnt;
	int mismatches = 0;
	int total_checks = 0;
	logic [7:0] masks [5] = '{8'h00, 8'h01, 8'h80, 8'hfe, 8'hff};
	logic [7:0] m;
	logic [2:0] e1, e2;

	hps_config #(.NUM_PORTS(NP)) uut (.I_CLK(clk), .I_RST(rst), .I_HSEL(hsel),
		.I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
		.I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
		.O_HRESP(hresp), .I_FN_DP_O(dp_o), .I_FN_DM_O(dm_o), .I_FN_DP_OE(dp_oe),
		.I_FN_DM_OE(dm_oe), .O_FN_DP_I(fdp_i), .O_FN_DM_I(fdm_i), .I_PIN_DP_I(pdp_i),
		.I_PIN_DM_I(pdm_i), .O_PIN_DP_O(pdp_o), .O_PIN_DM_O(pdm_o), .O_PIN_DP_OE(pdp_oe),
		.O_PIN_DM_OE(pdm_oe), .O_REMAP_ACTIVE(active), .O_PHYS1_LOGICAL(p1),
		.O_PHYS2_LOGICAL(p2), .O_PORT_COUNT(cnt));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog; the tests need well under a thousand cycles
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		#50000;
		mismatches++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and comparison
	task automatic end_of_test();
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// One AHB-Lite single transfer; address held until hready, data until hready
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= hps_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'h1);
		rd = hrdata;
		chk("hresp", {31'h0, hresp}, {31'h0, hps_pkg::HRESP_OKAY});
	endtask
	task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0);
		chk(name, rd, exp);
	endtask
	// Reserved field codes fall back to disabled
	function automatic logic [2:0] lmap(input logic [3:0] v);
		return v[3] ? 3'h0 : v[2:0];
	endfunction
	// Outputs are registered one edge behind the register, so settle two edges
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic map_chk(input logic [2:0] x1, input logic [2:0] x2, input logic on);
		logic [3:0] c;
		c = 4'h7 - 4'(x1 == 3'h0) - 4'(x2 == 3'h0);
		settle();
		chk("phys1", {29'h0, p1}, {29'h0, x1});
		chk("phys2", {29'h0, p2}, {29'h0, x2});
		chk("count", {28'h0, cnt}, {28'h0, c});
		chk("active", {31'h0, active}, {31'h0, on});
		chk("hready", {31'h0, hready}, 32'h0000_0001);
		rd_chk("status", hps_pkg::ADDR_STATUS, {15'h0, on, 4'h0, c, 1'h0, x2, 1'h0, x1});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst = 1'h1;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		dp_o = 8'h36;
		dm_o = 8'h0c;
		dp_oe = 8'hf0;
		dm_oe = 8'h3c;
		pdp_i = 8'h96;
		pdm_i = 8'h21;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		// Reset state and identity map
		rd_chk("swap_rst", hps_pkg::ADDR_SWAP, 32'h0);
		rd_chk("remap_rst", hps_pkg::ADDR_REMAP12, 32'h0);
		rd_chk("cfg3_rst", hps_pkg::ADDR_CFG_BYTE3, 32'h0);
		map_chk(3'h1, 3'h2, 1'h0);
		// Remap field ignored while enable is clear
		bus(1'h1, hps_pkg::ADDR_REMAP12, 32'h0000_0034);
		map_chk(3'h1, 3'h2, 1'h0);
		rd_chk("remap_rb", hps_pkg::ADDR_REMAP12, 32'h34);
		// Every code in both nibbles with the remap enabled
		bus(1'h1, hps_pkg::ADDR_CFG_BYTE3, 32'h0000_0008);
		for (int v = 0; v < 16; v++) begin
			bus(1'h1, hps_pkg::ADDR_REMAP12, {24'h0, 4'(v), 4'(15 - v)});
			e1 = lmap(4'(15 - v));
			e2 = lmap(4'(v));
			map_chk(e1, e2, 1'h1);
		end
		// A dense map as software must write it: port 2 takes number one
		bus(1'h1, hps_pkg::ADDR_REMAP12, 32'h0000_0012);
		map_chk(3'h2, 3'h1, 1'h1);
		// Clearing the enable restores the identity map
		bus(1'h1, hps_pkg::ADDR_CFG_BYTE3, 32'h0000_00f7);
		map_chk(3'h1, 3'h2, 1'h0);
		rd_chk("cfg3_rb", hps_pkg::ADDR_CFG_BYTE3, 32'hf7);
		// Swap masks, upstream bit and downstream bits, both directions
		for (int i = 0; i < 5; i++) begin
			m = masks[i];
			bus(1'h1, hps_pkg::ADDR_SWAP, {24'hffffff, m});
			dp_o <= dp_o + 8'h11;
			pdm_i <= ~pdm_i;
			settle();
			rd_chk("swap_rb", hps_pkg::ADDR_SWAP, {24'h0, m});
			chk("pin_dp_o", pdp_o, (dp_o & ~m) | (dm_o & m));
			chk("pin_dm_o", pdm_o, (dm_o & ~m) | (dp_o & m));
			chk("pin_dp_oe", pdp_oe, (dp_oe & ~m) | (dm_oe & m));
			chk("pin_dm_oe", pdm_oe, (dm_oe & ~m) | (dp_oe & m));
			chk("fn_dp_i", fdp_i, (pdp_i & ~m) | (pdm_i & m));
			chk("fn_dm_i", fdm_i, (pdm_i & ~m) | (pdp_i & m));
		end
		// Unmapped place reads zero and a write there changes nothing
		bus(1'h1, 32'h0000_0100, 32'hffff_ffff);
		rd_chk("unmapped", 32'h0000_0100, 32'h0);
		rd_chk("swap_kept", hps_pkg::ADDR_SWAP, 32'hff);
		end_of_test();
	end
endmodule
